/* core/olpb_pkg.sv */
// Purpose: shared constants and carrier types of the output latch / pulse / breaker-fail block
// Assumes: 10 MHz system clock, APB register access with 32-bit data
// Notes:   every offset, field position, reset value and time lives here, except the status bit order, which olpb_top sets
package olpb_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 100;
   localparam int MS_NS           = 1000000;
   localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
   localparam int PULSE_LONG_MS   = 80;
   localparam int PULSE_SHORT_MS  = 40;
   localparam int PULSE_CNT_W     = 8;
   localparam int BF_MS_W         = 10;
   localparam logic [BF_MS_W-1:0] BF_MS_RESET = 10'h064; // 100 ms
   localparam logic [BF_MS_W-1:0] BF_MS_MIN   = 10'h064; // 100 ms
   localparam logic [BF_MS_W-1:0] BF_MS_MAX   = 10'h3e8; // 1000 ms

   // ------------------------------------------------------------
   // switch positions (index = switch number - 1)
   // ------------------------------------------------------------
   localparam int SW_COUNT     = 8;
   localparam int SW_LATCH_A   = 0;
   localparam int SW_LATCH_B   = 1;
   localparam int SW_SIG_SHORT = 2;
   localparam int SW_PWR_SHORT = 3;
   localparam int SW_BF_EN     = 4;
   localparam logic [SW_COUNT-1:0] SW_RESET = 8'h00;

   // ------------------------------------------------------------
   // register map (byte addresses) and fields
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_SWITCHES  = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_SW_WRITE  = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_CHECKSUM  = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_BF_TIME   = 12'h00c;
   localparam logic [ADDR_W-1:0] ADDR_STATUS    = 12'h010;
   localparam int SWW_IDX_LSB = 0;
   localparam int SWW_IDX_MSB = 2;
   localparam int SWW_VAL_BIT = 8;
   localparam int STAT_W      = 8;

   // ------------------------------------------------------------
   // carriers and state types
   // ------------------------------------------------------------
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } olpb_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } olpb_apb_rsp_t;

   typedef struct packed {
      logic power_a_req;   // protection stage drives power_out_a
      logic power_b_req;   // protection stage drives power_out_b
      logic signal_a_req;
      logic signal_b_req;
      logic fault_present; // measured signal still above start value
   } olpb_trip_t;

   typedef struct packed {
      logic power_out_a;
      logic power_out_b;
      logic signal_out_a;
      logic signal_out_b;
   } olpb_out_t;

   typedef enum logic [1:0] {
      BF_IDLE,
      BF_TIMING,
      BF_OPERATE
   } olpb_bf_state_t;

   typedef struct packed {
      logic [PULSE_CNT_W-1:0] cnt;
      logic                   req_q;
      logic                   long_q;
      logic                   active;
   } olpb_stretch_t;

   typedef struct packed {
      logic [SW_COUNT-1:0] sw;
      logic [BF_MS_W-1:0]  bf_ms;
      olpb_bf_state_t      bf_state;
      logic [BF_MS_W-1:0]  bf_cnt;
      logic                bf_trip;
      logic                latched_a;
      logic                latched_b;
      olpb_out_t           outs;
      logic [31:0]         prdata;
      logic                pslverr;
      logic                rd_ok;
   } olpb_main_t;
endpackage : olpb_pkg

/* core/olpb_ms_tick.sv */
// Purpose: millisecond tick from the system clock
// Assumes: ce freezes the divider
// Notes:   tick is a one-cycle registered pulse every TICK_CYCLES enabled cycles
`timescale 1ns/1ps
`default_nettype none
module olpb_ms_tick #(
   parameter int TICK_CYCLES = olpb_pkg::TICK_CYCLES_DEF
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   output var  logic tick
);
   localparam int CW = $clog2(TICK_CYCLES);
   localparam int GW = CW + 1; // spare bit so a whole period fits
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } olpb_tick_t;
   olpb_tick_t s;
   olpb_tick_t next_s;

   // divider wraps at the period end and flags the tick
   always_comb begin
      next_s = s;
      if (s.cnt == CW'(TICK_CYCLES - 1)) begin
         next_s.cnt  = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt  = s.cnt + CW'(1);
         next_s.tick = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) s <= '0;
      else if (ce) s <= next_s;
   end
   assign tick = s.tick;

   // helper: enabled cycles since the last tick
   logic [GW-1:0] gap;
   always_ff @(posedge clk) begin
      if (srst) gap <= '0;
      else if (ce) gap <= s.tick ? GW'(1) : gap + GW'(1);
   end
   tick_period_a: assert property (@(posedge clk) disable iff (srst)
      $rose(s.tick) |-> gap == GW'(TICK_CYCLES))
      else $error("ms tick period wrong");
endmodule : olpb_ms_tick
`default_nettype wire

/* core/olpb_pulse_stretch.sv */
// Purpose: minimum pulse length for one output
// Assumes: tick is the ms tick, ce freezes state
// Notes:   loads min+1 ms so a tick right after the rise cannot cut the pulse short
`timescale 1ns/1ps
`default_nettype none
module olpb_pulse_stretch (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic tick,
   input  wire logic req,
   input  wire logic short_sel,
   output var  logic active
);
   olpb_pkg::olpb_stretch_t s;
   olpb_pkg::olpb_stretch_t next_s;
   localparam int PULSE_CNT_W = olpb_pkg::PULSE_CNT_W;

   // load on the request's rise, count ms down, hold while requested
   always_comb begin
      next_s = s;
      next_s.req_q = req;
      if (req && !s.req_q) begin
         next_s.long_q = !short_sel;
         next_s.cnt    = short_sel ? PULSE_CNT_W'(olpb_pkg::PULSE_SHORT_MS + 1)
                                   : PULSE_CNT_W'(olpb_pkg::PULSE_LONG_MS + 1);
      end else if (tick && s.cnt != '0) begin
         next_s.cnt = s.cnt - PULSE_CNT_W'(1);
      end
      next_s.active = req || (next_s.cnt != '0);
   end

   always_ff @(posedge clk) begin
      if (srst) s <= '0;
      else if (ce) s <= next_s;
   end
   assign active = s.active;

   // helper: ms ticks seen while the output stands
   logic [7:0] held;
   always_ff @(posedge clk) begin
      if (srst || !s.active) held <= '0;
      else if (ce && tick && held != 8'hff) held <= held + 8'h01;
   end
   min_pulse_a: assert property (@(posedge clk) disable iff (srst)
      $fell(s.active) |-> held > (s.long_q ? 8'(olpb_pkg::PULSE_LONG_MS)
                                           : 8'(olpb_pkg::PULSE_SHORT_MS)))
      else $error("output pulse shorter than minimum");
endmodule : olpb_pulse_stretch
`default_nettype wire

/* core/olpb_top.sv */
// Purpose: output configuration of a protection relay: latching, minimum pulse, breaker fail
// Assumes: 10 MHz clk, synchronous srst, APB slave with 32-bit data, trip inputs synchronous
// Notes:   outputs are registered; a trip reaches its contact two cycles after the request
//
// Notes on behaviour
// - The checksum is the sum of each switch position times weight 2^(n-1), 1 up to 128.
// - Each switch can be written alone without disturbing the other seven.
// - Switch 1 selects latching for power_out_a, switch 2 for power_out_b.
// - With the latch switch at 0 the power output drops once its tripping signal falls.
// - With the latch switch at 1 the power output stays on until it is unlatched.
// - An unlatch command from the operator panel clears a latched power output.
// - Signal outputs are held at least 80 ms with switch 3 at 0 and 40 ms with it at 1.
// - Power outputs are held at least 80 ms with switch 4 at 0 and 40 ms with it at 1.
// - Latching of a power output overrides its minimum pulse length.
// - With switch 5 at 0 the breaker-fail timer is off and never drives power_out_b.
// - With switch 5 at 1 a trip on power_out_a starts a timer that trips power_out_b.
// - After reset all switches read 0 and the checksum is 0; switches 6 to 8 do nothing.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module olpb_top #(
   parameter int TICK_CYCLES = olpb_pkg::TICK_CYCLES_DEF
) (
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    ce,
   input  wire olpb_pkg::olpb_apb_req_t apb_req,
   output var  olpb_pkg::olpb_apb_rsp_t apb_rsp,
   input  wire olpb_pkg::olpb_trip_t    trip,
   input  wire logic                    unlatch_cmd,
   output var  olpb_pkg::olpb_out_t     outs
);
   // ------------------------------------------------------------
   // state and reset value
   // ------------------------------------------------------------
   localparam olpb_pkg::olpb_main_t MAIN_RESET = '{
      sw:        olpb_pkg::SW_RESET,
      bf_ms:     olpb_pkg::BF_MS_RESET,
      bf_state:  olpb_pkg::BF_IDLE,
      bf_cnt:    '0,
      bf_trip:   1'b0,
      latched_a: 1'b0,
      latched_b: 1'b0,
      outs:      '0,
      prdata:    '0,
      pslverr:   1'b0,
      rd_ok:     1'b0
   };

   olpb_pkg::olpb_main_t s;
   olpb_pkg::olpb_main_t next_s;
   logic                 tick;
   logic                 str_pa;
   logic                 str_pb;
   logic                 str_sa;
   logic                 str_sb;
   logic                 pready;
   logic                 done;
   logic                 wr;
   logic                 hit;
   logic [31:0]          rd_mux;
   logic [7:0]           checksum;

   // ------------------------------------------------------------
   // checksum
   // ------------------------------------------------------------
   // weighted sum kept explicit so it stays right if the layout ever changes
   function automatic logic [7:0] olpb_sum(input logic [7:0] sw);
      logic [7:0] acc;
      acc = '0;
      for (int i = 0; i < olpb_pkg::SW_COUNT; i++) begin
         if (sw[i]) acc = acc + 8'(1 << i);
      end
      return acc;
   endfunction : olpb_sum

   assign checksum = olpb_sum(s.sw);

   // ------------------------------------------------------------
   // leaves: ms tick and four minimum-pulse stretchers
   // ------------------------------------------------------------
   olpb_ms_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .tick (tick)
   );

   // breaker-fail trip joins the stage request for power_out_b
   olpb_pulse_stretch u_str_pa (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .tick      (tick),
      .req       (trip.power_a_req),
      .short_sel (s.sw[olpb_pkg::SW_PWR_SHORT]),
      .active    (str_pa)
   );
   olpb_pulse_stretch u_str_pb (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .tick      (tick),
      .req       (trip.power_b_req | s.bf_trip),
      .short_sel (s.sw[olpb_pkg::SW_PWR_SHORT]),
      .active    (str_pb)
   );
   olpb_pulse_stretch u_str_sa (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .tick      (tick),
      .req       (trip.signal_a_req),
      .short_sel (s.sw[olpb_pkg::SW_SIG_SHORT]),
      .active    (str_sa)
   );
   olpb_pulse_stretch u_str_sb (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .tick      (tick),
      .req       (trip.signal_b_req),
      .short_sel (s.sw[olpb_pkg::SW_SIG_SHORT]),
      .active    (str_sb)
   );

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   // read data is captured a cycle ahead so prdata comes from a flop
   assign pready  = ce & apb_req.psel & apb_req.penable & s.rd_ok;
   assign done    = apb_req.psel & apb_req.penable & pready;
   assign wr      = done & apb_req.pwrite;
   assign apb_rsp = '{prdata: s.prdata, pready: pready, pslverr: s.pslverr};

   // read mux and address decode; unmapped reads zero and flags an error
   always_comb begin
      rd_mux = '0;
      hit    = 1'b1;
      case (apb_req.paddr)
         olpb_pkg::ADDR_SWITCHES: rd_mux[olpb_pkg::SW_COUNT-1:0] = s.sw;
         olpb_pkg::ADDR_SW_WRITE: rd_mux = '0;
         olpb_pkg::ADDR_CHECKSUM: rd_mux[7:0] = checksum;
         olpb_pkg::ADDR_BF_TIME:  rd_mux[olpb_pkg::BF_MS_W-1:0] = s.bf_ms;
         olpb_pkg::ADDR_STATUS:   rd_mux[olpb_pkg::STAT_W-1:0] = {
            s.bf_state == olpb_pkg::BF_OPERATE,
            s.bf_state == olpb_pkg::BF_TIMING,
            s.latched_b, s.latched_a,
            s.outs.signal_out_b, s.outs.signal_out_a,
            s.outs.power_out_b, s.outs.power_out_a};
         default: hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;

      // capture answer during setup and any waiting access cycle
      if (apb_req.psel && !done) begin
         next_s.prdata  = rd_mux;
         next_s.pslverr = !hit;
         next_s.rd_ok   = 1'b1;
      end else begin
         next_s.rd_ok   = 1'b0;
      end

      // register writes take effect only at the completing edge
      if (wr) begin
         case (apb_req.paddr)
            olpb_pkg::ADDR_SWITCHES:
               next_s.sw = apb_req.pwdata[olpb_pkg::SW_COUNT-1:0];
            olpb_pkg::ADDR_SW_WRITE: // single switch, others untouched
               next_s.sw[apb_req.pwdata[olpb_pkg::SWW_IDX_MSB:olpb_pkg::SWW_IDX_LSB]] =
                  apb_req.pwdata[olpb_pkg::SWW_VAL_BIT];
            olpb_pkg::ADDR_BF_TIME: begin
               // operate time is clamped to its legal range
               if (apb_req.pwdata < 32'(olpb_pkg::BF_MS_MIN))
                  next_s.bf_ms = olpb_pkg::BF_MS_MIN;
               else if (apb_req.pwdata > 32'(olpb_pkg::BF_MS_MAX))
                  next_s.bf_ms = olpb_pkg::BF_MS_MAX;
               else
                  next_s.bf_ms = apb_req.pwdata[olpb_pkg::BF_MS_W-1:0];
            end
            default: ;
         endcase
      end

      // latch: a live request sets, unlatch clears, set wins
      next_s.latched_a = s.sw[olpb_pkg::SW_LATCH_A] &
                         (trip.power_a_req | (s.latched_a & ~unlatch_cmd));
      next_s.latched_b = s.sw[olpb_pkg::SW_LATCH_B] &
                         (trip.power_b_req | s.bf_trip | (s.latched_b & ~unlatch_cmd));

      // breaker-fail timer counts ms while the fault stays
      case (s.bf_state)
         olpb_pkg::BF_IDLE: begin
            if (trip.power_a_req && trip.fault_present) begin
               next_s.bf_state = olpb_pkg::BF_TIMING;
               next_s.bf_cnt   = '0;
            end
         end
         olpb_pkg::BF_TIMING: begin
            if (!trip.fault_present) begin
               next_s.bf_state = olpb_pkg::BF_IDLE;
            end else if (tick) begin
               if (s.bf_cnt + 10'h001 >= s.bf_ms) next_s.bf_state = olpb_pkg::BF_OPERATE;
               else next_s.bf_cnt = s.bf_cnt + 10'h001;
            end
         end
         olpb_pkg::BF_OPERATE: begin
            if (!trip.fault_present) next_s.bf_state = olpb_pkg::BF_IDLE;
         end
         default: next_s.bf_state = olpb_pkg::BF_IDLE;
      endcase
      if (!s.sw[olpb_pkg::SW_BF_EN]) next_s.bf_state = olpb_pkg::BF_IDLE;
      next_s.bf_trip = (next_s.bf_state == olpb_pkg::BF_OPERATE);

      // latched state overrides the pulse stretcher on power outputs
      next_s.outs.power_out_a  = str_pa | s.latched_a;
      next_s.outs.power_out_b  = str_pb | s.latched_b;
      next_s.outs.signal_out_a = str_sa;
      next_s.outs.signal_out_b = str_sb;
   end

   // reset wins over ce so a frozen block still comes up clean
   always_ff @(posedge clk) begin
      if (srst) s <= MAIN_RESET;
      else if (ce) s <= next_s;
   end
   assign outs = s.outs;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence sw_wr_s;
      wr && apb_req.paddr == olpb_pkg::ADDR_SW_WRITE;
   endsequence
   sequence bf_expire_s;
      s.bf_state == olpb_pkg::BF_TIMING && trip.fault_present && tick
         && s.bf_cnt + 10'h001 >= s.bf_ms;
   endsequence

   checksum_read_a: assert property (
      done && !apb_req.pwrite && apb_req.paddr == olpb_pkg::ADDR_CHECKSUM
         |-> apb_rsp.prdata == {24'h000000, s.sw})
      else $error("checksum readback wrong");
   single_switch_a: assert property (sw_wr_s and ce |=>
      ((s.sw ^ $past(s.sw)) & ~(8'h01 << $past(apb_req.pwdata[2:0]))) == 8'h00
         && s.sw[$past(apb_req.pwdata[2:0])] == $past(apb_req.pwdata[8]))
      else $error("switch write disturbed other switches");
   latch_set_a: assert property (
      ce && s.sw[olpb_pkg::SW_LATCH_B] && trip.power_b_req |=> s.latched_b)
      else $error("latch of power_out_b not set");
   no_latch_a: assert property (
      ce && !s.sw[olpb_pkg::SW_LATCH_A] |=> !s.latched_a)
      else $error("power_out_a latched while latching off");
   latch_hold_a: assert property (
      ce && s.latched_a && s.sw[olpb_pkg::SW_LATCH_A] && !unlatch_cmd |=> s.latched_a)
      else $error("latched power_out_a dropped");
   unlatch_clear_a: assert property (
      ce && unlatch_cmd && !trip.power_a_req |=> !s.latched_a)
      else $error("unlatch command ignored");
   latch_wins_a: assert property (
      ce && s.latched_a |=> s.outs.power_out_a)
      else $error("latched output not driven");
   bf_off_a: assert property (
      !s.sw[olpb_pkg::SW_BF_EN] && ce |=> !s.bf_trip ##1 !s.bf_trip || !ce)
      else $error("breaker fail active while disabled");
   bf_fire_a: assert property (
      bf_expire_s and ce and s.sw[olpb_pkg::SW_BF_EN] |=> s.bf_trip)
      else $error("breaker fail did not fire on expiry");
   bf_cause_a: assert property (
      $rose(s.bf_trip) |-> $past(s.bf_state) == olpb_pkg::BF_TIMING && $past(tick))
      else $error("breaker fail fired without timing");
   reset_zero_a: assert property (
      $fell(srst) |-> s.sw == olpb_pkg::SW_RESET && checksum == 8'h00)
      else $error("switches not zero after reset");
endmodule : olpb_top
`default_nettype wire

/* test/olpb_breaker_model.sv */
// Purpose: breaker and fault source seen from the power contacts
// Assumes: coil is high while either power contact is closed
// Notes:   stuck keeps the breaker closed, so the fault stays until it is freed
`timescale 1ns/1ps
`default_nettype none
module olpb_breaker_model #(
   parameter int OPEN_CYCLES = 40
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic coil,
   input  wire logic stuck,
   input  wire logic fault_start,
   output var  logic fault_present
);
   int unsigned energised;

   // breaker opens only after the coil has pulled long enough; a stuck one never does
   always @(posedge clk) begin
      if (srst) begin
         fault_present <= 1'b0;
         energised     <= 0;
      end else begin
         energised <= coil ? energised + 1 : 0;
         if (fault_start)
            fault_present <= 1'b1;
         else if (!stuck && energised >= OPEN_CYCLES)
            fault_present <= 1'b0;
      end
   end
endmodule : olpb_breaker_model
`default_nettype wire

/* test/test_output_latch_pulse_breaker_fail.sv */
// Purpose: self-checking bench for olpb_top with a breaker model on the contacts
// Assumes: TICK_CYCLES of 10, so one ms is ten clk cycles
// Notes:   lengths are counted on rising edges; bounds allow for the tick phase
`timescale 1ns/1ps
`default_nettype none
module test_output_latch_pulse_breaker_fail;
   // ------------------------------------------------------------
   // design, breaker model and stimulus
   // ------------------------------------------------------------
   localparam int T = 10;
   logic                    clk         = 1'b0;
   logic                    srst        = 1'b1;
   logic                    ce          = 1'b1;
   olpb_pkg::olpb_apb_req_t apb_req     = '0;
   olpb_pkg::olpb_apb_rsp_t apb_rsp;
   logic [3:0]              req         = 4'h0; // power a, power b, signal a, signal b
   logic                    unlatch_cmd = 1'b0;
   logic                    fault_start = 1'b0;
   logic                    stuck       = 1'b0;
   logic                    fault_present;
   olpb_pkg::olpb_out_t     outs;
   int                      errors      = 0;
   int                      n_tests     = 0;
   int                      hi;
   int                      bf_ms;
   logic [31:0]             q;
   logic                    err;
   logic [7:0]              v;

   always #50 clk = ~clk;

   olpb_top #(.TICK_CYCLES(T)) dut_u (
      .clk         (clk),
      .srst        (srst),
      .ce          (ce),
      .apb_req     (apb_req),
      .apb_rsp     (apb_rsp),
      .trip        ({req, fault_present}),
      .unlatch_cmd (unlatch_cmd),
      .outs        (outs)
   );

   olpb_breaker_model breaker_u (
      .clk           (clk),
      .srst          (srst),
      .coil          (outs.power_out_a | outs.power_out_b),
      .stuck         (stuck),
      .fault_start   (fault_start),
      .fault_present (fault_present)
   );

   // ------------------------------------------------------------
   // tasks and expectations
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] csum(input logic [7:0] s);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < 8; i++)
         r += s[i] ? (32'h1 << i) : 32'h0;
      return r;
   endfunction : csum

   // a random ce freeze in setup makes the slave add wait states
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int w;
      @(posedge clk);
      apb_req.psel    <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite  <= wr;
      apb_req.paddr   <= a;
      apb_req.pwdata  <= d;
      ce              <= ($urandom % 4 != 0);
      @(posedge clk);
      apb_req.penable <= 1'b1;
      ce              <= 1'b1;
      w = 0;
      do begin
         @(posedge clk);
         w++;
      end while (apb_rsp.pready !== 1'b1 && w < 50);
      chk(32'(w < 50), 32'h1);
      q               = apb_rsp.prdata;
      err             = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd

   // request for cyc cycles; hi counts cycles the matching output stood high
   task automatic run_req(input int k, input int cyc);
      int c;
      c  = 0;
      hi = 0;
      @(posedge clk);
      req[k] <= 1'b1;
      while (c < 4000 && !(hi > 0 && outs[k] !== 1'b1)) begin
         @(posedge clk);
         c++;
         if (c == cyc)
            req[k] <= 1'b0;
         if (outs[k] === 1'b1)
            hi++;
      end
   endtask : run_req

   task automatic complete_run();
      if (errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      $display("BAD %0t watchdog expired", $time);
      complete_run();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      hi = $urandom(32);
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd(olpb_pkg::ADDR_SWITCHES, 32'h0);
      rd(olpb_pkg::ADDR_CHECKSUM, 32'h0);
      rd(olpb_pkg::ADDR_BF_TIME, 32'(olpb_pkg::BF_MS_RESET));
      rd(12'h014, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b1, olpb_pkg::ADDR_CHECKSUM, 32'hff);
      rd(olpb_pkg::ADDR_CHECKSUM, 32'h0);
      // group writes: the worked example, all ones, then random
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'h55 : (i == 1) ? 8'hff : 8'($urandom);
         apb(1'b1, olpb_pkg::ADDR_SWITCHES, 32'(v));
         rd(olpb_pkg::ADDR_SWITCHES, 32'(v));
         rd(olpb_pkg::ADDR_CHECKSUM, csum(v));
      end
      for (int i = 0; i < 8; i++) begin
         v[i] = 1'($urandom);
         apb(1'b1, olpb_pkg::ADDR_SW_WRITE, (32'(v[i]) << olpb_pkg::SWW_VAL_BIT) | 32'(i));
         rd(olpb_pkg::ADDR_SWITCHES, 32'(v));
      end
      apb(1'b1, olpb_pkg::ADDR_BF_TIME, 32'h5);
      rd(olpb_pkg::ADDR_BF_TIME, 32'(olpb_pkg::BF_MS_MIN));
      bf_ms = 100 + $urandom % 101;
      apb(1'b1, olpb_pkg::ADDR_BF_TIME, 32'(bf_ms));
      rd(olpb_pkg::ADDR_BF_TIME, 32'(bf_ms));
      // one-cycle requests on each output, both lengths, idle switches random
      for (int k = 0; k < 4; k++) begin
         for (int s = 0; s < 2; s++) begin
            v = (8'($urandom) & 8'he0) | ((s == 0) ? 8'h00 : (k >= 2) ? 8'h08 : 8'h04);
            apb(1'b1, olpb_pkg::ADDR_SWITCHES, 32'(v));
            run_req(k, 1);
            chk(32'(hi >= (80 - 40 * s) * T && hi <= (81 - 40 * s) * T + 2), 32'h1);
         end
      end
      apb(1'b1, olpb_pkg::ADDR_SWITCHES, 32'h0);
      run_req(3, 1500);
      chk(32'(hi >= 1498 && hi <= 1502), 32'h1);
      // latch one output only; the other keeps its short pulse
      for (int k = 2; k < 4; k++) begin
         apb(1'b1, olpb_pkg::ADDR_SWITCHES, (k == 3) ? 32'h9 : 32'ha);
         run_req(5 - k, 1);
         chk(32'(hi >= 40 * T && hi <= 41 * T + 2), 32'h1);
         run_req(k, 1);
         chk(32'(hi > 3990), 32'h1);
         rd(olpb_pkg::ADDR_STATUS, (k == 3) ? 32'h11 : 32'h22);
         @(posedge clk);
         unlatch_cmd <= 1'b1;
         @(posedge clk);
         unlatch_cmd <= 1'b0;
         repeat (3) @(posedge clk);
         chk(32'(outs), 32'h0);
      end
      // timer off with stuck breaker, on with stuck breaker, on with healthy breaker
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, olpb_pkg::ADDR_SWITCHES, (i == 0) ? 32'h0 : 32'h10);
         @(posedge clk);
         stuck       <= (i != 2);
         fault_start <= 1'b1;
         @(posedge clk);
         fault_start <= 1'b0;
         req[3]      <= 1'b1;
         @(posedge clk);
         req[3]      <= 1'b0;
         hi = 0;
         while (outs.power_out_b !== 1'b1 && hi < (bf_ms + 50) * T) begin
            @(posedge clk);
            hi++;
         end
         if (i == 1)
            chk(32'(hi >= (bf_ms - 1) * T && hi <= (bf_ms + 1) * T + 4), 32'h1);
         else
            chk(32'(hi), 32'((bf_ms + 50) * T));
         // stuck breaker: timer in operate, only power_out_b standing
         if (i == 1)
            rd(olpb_pkg::ADDR_STATUS, 32'h82);
         // re-trip with a freed breaker so the fault clears
         @(posedge clk);
         stuck  <= 1'b0;
         req[3] <= 1'b1;
         @(posedge clk);
         req[3] <= 1'b0;
         hi = 0;
         while ((outs !== 4'h0 || fault_present !== 1'b0) && hi < 3000) begin
            @(posedge clk);
            hi++;
         end
         chk(32'(outs), 32'h0);
      end
      // mid-run reset must bring modified switches and time back to default
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(olpb_pkg::ADDR_SWITCHES, 32'h0);
      rd(olpb_pkg::ADDR_CHECKSUM, 32'h0);
      rd(olpb_pkg::ADDR_BF_TIME, 32'(olpb_pkg::BF_MS_RESET));
      complete_run();
   end
endmodule : test_output_latch_pulse_breaker_fail
`default_nettype wire
